// *** bench/dynrc_testbench.sv ***
// Purpose: self-checking bench for the dynamics control and configuration block
// Assumes: bench acts as axi4-lite master, design runs with default clock parameters
// Notes: gain is checked every sample against the given bounds (floor and ceiling in the gain test), and against a one-step limit unless the two are equal
`timescale 1ns/1ps
`default_nettype none
module testbench
   import dynrc_pkg::*;
;
   localparam logic [13:0] A_CTL = {DYNRC_IDX_CONTROL, 2'b00};
   localparam logic [13:0] A_TIM = {DYNRC_IDX_TIMING, 2'b00};
   localparam logic [13:0] A_STA = {DYNRC_IDX_STATUS, 2'b00};
   localparam logic [13:0] A_MSK = {DYNRC_IDX_MASK, 2'b00};
   localparam logic [13:0] A_KN2 = {DYNRC_IDX_KNEE2, 2'b00};
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [13:0] awaddr = '0;
   logic [13:0] araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, strobe = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hF;
   logic [7:0] target = 8'h48, crest = 8'h00, rms = 8'hFF;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd_d;
   logic ena, path, clip, qr, ng, k2act, present, irq;
   logic [4:0] k2lvl;
   logic [7:0] gain;
   int failures = 0;
   int compares = 0;
   logic [15:0] g_tim [9] = '{16'h0204, 16'h0204, 16'h0209, 16'h020D, 16'h0211, 16'h0213, 16'h0203, 16'h0201, 16'h0202};
   logic [7:0] g_tgt [9] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF};
   logic [7:0] g_lo [9] = '{8'h30, 8'h30, 8'h24, 8'h18, 8'h00, 8'h00, 8'h48, 8'h48, 8'h48};
   logic [7:0] g_hi [9] = '{8'h60, 8'h60, 8'h6C, 8'h6C, 8'h6C, 8'h90, 8'h90, 8'h6C, 8'h78};

   dynrc_config i_dut (
      .clk(clk), .srst(srst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sample_strobe(strobe), .target_gain(target), .crest_level(crest), .rms_level(rms),
      .dyn_enable(ena), .dyn_path_select(path), .anti_clip_enable(clip),
      .quick_release_enable(qr), .noise_gate_enable(ng), .second_knee_out_level(k2lvl),
      .second_knee_active(k2act), .applied_gain(gain), .signal_present(present), .irq(irq)
   );

   initial begin
      forever #20 clk = ~clk;
   end

   task automatic results();
      if (failures == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [13:0] a, input logic [15:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      r = 2'h3;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {16'h0000, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 50 && !done; i++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            done = 1;
         end
      end
      if (!done) failures++;
      @(posedge clk);
   endtask

   task automatic rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      d = '0;
      r = 2'h3;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 50 && !done; i++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1;
         end
      end
      if (!done) failures++;
      @(posedge clk);
   endtask

   task automatic rdchk(input string what, input logic [13:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(what, d, exp);
   endtask

   // one strobe per pass; step check skipped when the two given bounds are equal
   task automatic samples(input int n, input logic [7:0] lo, input logic [7:0] hi);
      logic [7:0] prev;
      for (int i = 0; i < n; i++) begin
         prev = gain;
         strobe <= 1'b1;
         @(posedge clk);
         strobe <= 1'b0;
         @(posedge clk);
         @(posedge clk);
         chk("gain range", (gain >= lo && gain <= hi), 1);
         if (lo != hi) chk("gain step", 8'(gain - prev + 8'h01) <= 8'h02, 1);
      end
   endtask

   task automatic t_reset();
      rdchk("control reset", A_CTL, 32'h0000000C);
      rdchk("timing reset", A_TIM, 32'h00000925);
      chk("outputs reset", {ng, k2act, qr, clip, path, ena}, 6'b001100);
      chk("gain reset", gain, 8'h48);
      chk("present reset", present, 0);
   endtask

   task automatic t_ctrl();
      logic [15:0] v;
      for (int b = 0; b < 8; b++) begin
         v = 16'h0001 << b;
         wr(A_CTL, v, rs);
         chk("control outputs", {ng, k2act, qr, clip, path, ena}, {v[7], v[4], v[3], v[2], v[1], v[0]});
         rdchk("control readback", A_CTL, {16'h0000, v});
      end
      wr(A_CTL, 16'hFFFF, rs);
      rdchk("control fields", A_CTL, 32'h00007FFF);
      wr(A_KN2, 16'h0015, rs);
      wr(A_CTL, 16'h0000, rs);
      chk("knee level off", k2lvl, 5'h00);
      wr(A_CTL, 16'h0010, rs);
      chk("knee level on", k2lvl, 5'h15);
   endtask

   task automatic t_unmapped();
      rd(14'h3FC, rd_d, rs);
      chk("unmapped read resp", rs, AXI_SLVERR);
      chk("unmapped read data", rd_d, 32'h00000000);
      wr(14'h3FC, 16'hFFFF, rs);
      chk("unmapped write resp", rs, AXI_SLVERR);
   endtask

   task automatic t_gain();
      wr(A_CTL, 16'h0001, rs);
      for (int e = 0; e < 9; e++) begin
         wr(A_TIM, g_tim[e], rs);
         target <= g_tgt[e];
         samples(1000, g_lo[e], g_hi[e]);
         chk("gain settled", gain, (g_tgt[e] != 8'h00) ? g_hi[e] : g_lo[e]);
      end
      wr(A_CTL, 16'h0000, rs);
      target <= 8'h48;
      samples(1, 8'h48, 8'h48);
   endtask

   task automatic t_presence();
      logic [7:0] thr;
      for (int c = 0; c < 4; c++) begin
         thr = 8'(28 + 12 * c);
         wr(A_CTL, 16'h0021 | 16'(c << 8), rs);
         crest <= thr + 8'h01;
         samples(1, 8'h00, 8'hFF);
         chk("present peak above", present, 1);
         crest <= thr - 8'h01;
         samples(1, 8'h00, 8'hFF);
         chk("present peak below", present, 0);
      end
      crest <= 8'h00;
      for (int c = 0; c < 32; c += 31) begin
         thr = 8'(54 + 3 * c);
         wr(A_CTL, 16'h0061 | 16'(c << 10), rs);
         rms <= thr - 8'h01;
         samples(1, 8'h00, 8'hFF);
         chk("present rms above", present, 1);
         rms <= thr + 8'h01;
         samples(1, 8'h00, 8'hFF);
         chk("present rms below", present, 0);
      end
      rms <= 8'h00;
      crest <= 8'hFF;
      wr(A_CTL, 16'h0001, rs);
      samples(1, 8'h00, 8'hFF);
      chk("present detect off", present, 0);
      wr(A_CTL, 16'h0060, rs);
      samples(1, 8'h00, 8'hFF);
      chk("present ctrl off", present, 0);
   endtask

   task automatic t_irq();
      chk("irq masked", irq, 0);
      rd(A_STA, rd_d, rs);
      wr(A_MSK, 16'h0001, rs);
      wr(A_CTL, 16'h0061, rs);
      samples(1, 8'h00, 8'hFF);
      @(posedge clk);
      chk("irq on presence", irq, 1);
      rdchk("status presence", A_STA, 32'h00000001);
      chk("irq after clear", irq, 0);
      wr(A_MSK, 16'h0002, rs);
      wr(A_TIM, 16'h0004, rs);
      @(posedge clk);
      chk("irq reserved attack", irq, 1);
      rdchk("status reserved attack", A_STA, 32'h00000002);
      wr(A_TIM, 16'h0925, rs);
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      failures++;
      results();
   end

   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_ctrl();
      t_unmapped();
      t_gain();
      t_presence();
      t_irq();
      results();
   end
endmodule
`default_nettype wire

// *** shared/dynrc_pkg.sv ***
// Purpose: constants for the dynamic range controller configuration block
// Assumes: axi4-lite register access, 32-bit data
// Notes: printed offsets are register indices, byte address is four times
package dynrc_pkg;
   localparam logic [11:0] DYNRC_IDX_CONTROL = 12'h114;
   localparam logic [11:0] DYNRC_IDX_TIMING = 12'h115;
   localparam logic [11:0] DYNRC_IDX_STATUS = 12'h120;
   localparam logic [11:0] DYNRC_IDX_MASK = 12'h121;
   localparam logic [11:0] DYNRC_IDX_KNEE2 = 12'h122;
   localparam int DYNRC_ADDR_W = 14;
   localparam logic [15:0] DYNRC_CTRL_RESET = 16'h000C;
   localparam logic [15:0] DYNRC_CTRL_MASK = 16'h7FFF;
   localparam logic [15:0] DYNRC_TIME_RESET = 16'h0925;
   localparam logic [15:0] DYNRC_TIME_MASK = 16'h1FFF;
   localparam int B_ENA = 0;
   localparam int B_PATH = 1;
   localparam int B_CLIP = 2;
   localparam int B_QR = 3;
   localparam int B_K2 = 4;
   localparam int B_DET = 5;
   localparam int B_DMODE = 6;
   localparam int B_NG = 7;
   localparam int F_PK_LO = 8;
   localparam int F_RMS_LO = 10;
   localparam int F_MAXG_LO = 0;
   localparam int F_MING_LO = 2;
   localparam int F_DCY_LO = 5;
   localparam int F_ATK_LO = 9;
   localparam logic [3:0] ATK_FIRST = 4'h1;
   localparam logic [3:0] ATK_LAST = 4'hB;
   localparam logic [2:0] MING_LAST = 3'h4;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   // gain in 0.5 dB units, offset by 72 so 0 is -36 dB
   localparam logic [7:0] GAIN_ZERO = 8'h48;
   // fastest rate step time, 181 us per 6 dB = 12 half-dB steps
   localparam int ATK_BASE_NS = 181000;
   localparam int DCY_BASE_NS = 1450000;
   localparam int HALF_DB_STEPS = 12;
endpackage

// *** verilog/dynrc_config.sv ***
// Purpose: register file and gain/presence control of the dynamic range controller
// Assumes: one clock, sample strobe from the audio path, levels in 0.5 dB units
// Notes: status is read-to-clear, a set in the same cycle wins
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - bit 0 switches the controller on, reset off.
// - bit 1 selects recording path at 0 and playback path at 1, reset 0.
// - bit 2 enables anti-clip, reset on.
// - bit 3 enables quick release, reset on.
// - bit 4 enables the second knee output level, reset 0.
// - bit 5 enables presence detection, reset 0.
// - bit 6 picks crest factor compare at 0 and rms compare at 1.
// - bit 7 enables the noise gate, reset 0.
// - in peak mode presence needs crest factor above 14, 20, 26 or 32 dB by code.
// - in rms mode presence needs rms level above -27 dB less 1.5 dB per code.
// - attack field gives 181 us per 6 dB at code 1 doubling to code 11, reset 4.
// - decay field gives 1.45 ms per 6 dB at code 0 doubling to code 15, reset 9.
// - floor field gives 0, -12, -18, -24 or -36 dB, reset -12 dB.
// - ceiling field gives 12, 18, 24 or 36 dB, reset 18 dB.
// - the second knee level acts only while its enable is set.
module dynrc_config
   import dynrc_pkg::*;
#(
   parameter int CLK_HZ = 25000000,
   parameter int FS_HZ = 48000
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [DYNRC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [DYNRC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sample_strobe,
   input wire logic [7:0] target_gain,
   input wire logic [7:0] crest_level,
   input wire logic [7:0] rms_level,
   output logic dyn_enable,
   output logic dyn_path_select,
   output logic anti_clip_enable,
   output logic quick_release_enable,
   output logic noise_gate_enable,
   output logic [4:0] second_knee_out_level,
   output logic second_knee_active,
   output logic [7:0] applied_gain,
   output logic signal_present,
   output logic irq
);
   typedef enum logic [2:0] {
      DYNRC_W_IDLE = 3'b001,
      DYNRC_W_HAVE = 3'b010,
      DYNRC_W_RESP = 3'b100
   } dynrc_wst_e;

   logic [15:0] ctrl_reg;
   logic [15:0] time_reg;
   logic [4:0] knee2_reg;
   logic [2:0] stat_reg;
   logic [2:0] mask_reg;
   logic [7:0] gain_reg;
   logic present_reg;
   logic [31:0] rate_cnt_reg;
   logic [31:0] rate_next;
   dynrc_wst_e wst_reg;
   logic have_aw_reg, have_w_reg;
   logic [DYNRC_ADDR_W-1:0] waddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [31:0] rdata_next;
   logic rd_hit, wr_hit, wr_fire;
   logic [7:0] floor_g, ceil_g;
   logic [7:0] crest_thr, rms_thr;
   logic det_now;
   logic [2:0] stat_set;
   logic [7:0] gain_next;

   function automatic logic [11:0] word_idx(input logic [DYNRC_ADDR_W-1:0] a);
      return a[DYNRC_ADDR_W-1:2];
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] s, input logic [15:0] m);
      logic [15:0] r;
      r = old;
      if (s[0]) r[7:0] = d[7:0];
      if (s[1]) r[15:8] = d[15:8];
      return r & m;
   endfunction

   // cycles per half-dB step: base per-6dB time scaled by 2^shift
   function automatic logic [31:0] step_cycles(input int base_ns, input logic [3:0] shift);
      longint t;
      t = (longint'(base_ns) << shift) / HALF_DB_STEPS;
      t = (t * CLK_HZ) / 64'd1000000000;
      if (t < 1) t = 1;
      return t[31:0];
   endfunction

   // register decode shared by read and write
   function automatic logic idx_mapped(input logic [11:0] i);
      return i == DYNRC_IDX_CONTROL || i == DYNRC_IDX_TIMING || i == DYNRC_IDX_STATUS ||
             i == DYNRC_IDX_MASK || i == DYNRC_IDX_KNEE2;
   endfunction

   // write channel: address and data in either order
   assign s_axi_awready = (wst_reg != DYNRC_W_RESP) && !have_aw_reg;
   assign s_axi_wready = (wst_reg != DYNRC_W_RESP) && !have_w_reg;
   assign wr_fire = (wst_reg != DYNRC_W_RESP) && (have_aw_reg || s_axi_awvalid) &&
                    (have_w_reg || s_axi_wvalid);
   assign wr_hit = idx_mapped(word_idx(have_aw_reg ? waddr_reg : s_axi_awaddr));

   always_ff @(posedge clk) begin
      if (srst) begin
         wst_reg <= DYNRC_W_IDLE;
         have_aw_reg <= 1'b0;
         have_w_reg <= 1'b0;
         waddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            have_aw_reg <= 1'b1;
            waddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            have_w_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         case (wst_reg)
            DYNRC_W_IDLE, DYNRC_W_HAVE: begin
               if (wr_fire) begin
                  wst_reg <= DYNRC_W_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
               end else if (have_aw_reg || have_w_reg) begin
                  wst_reg <= DYNRC_W_HAVE;
               end
            end
            DYNRC_W_RESP: begin
               have_aw_reg <= 1'b0;
               have_w_reg <= 1'b0;
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wst_reg <= DYNRC_W_IDLE;
               end
            end
            default: wst_reg <= DYNRC_W_IDLE;
         endcase
      end
   end

   logic [11:0] wi;
   logic [31:0] wd;
   logic [3:0] ws;
   assign wi = word_idx(have_aw_reg ? waddr_reg : s_axi_awaddr);
   assign wd = have_w_reg ? wdata_reg : s_axi_wdata;
   assign ws = have_w_reg ? wstrb_reg : s_axi_wstrb;

   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_reg <= DYNRC_CTRL_RESET;
         time_reg <= DYNRC_TIME_RESET;
         knee2_reg <= '0;
         mask_reg <= '0;
      end else if (wr_fire) begin
         if (wi == DYNRC_IDX_CONTROL) ctrl_reg <= merge16(ctrl_reg, wd, ws, DYNRC_CTRL_MASK);
         if (wi == DYNRC_IDX_TIMING) time_reg <= merge16(time_reg, wd, ws, DYNRC_TIME_MASK);
         if (wi == DYNRC_IDX_MASK && ws[0]) mask_reg <= wd[2:0];
         if (wi == DYNRC_IDX_KNEE2 && ws[0]) knee2_reg <= wd[4:0];
      end
   end

   // read channel, one outstanding read
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_hit = idx_mapped(word_idx(s_axi_araddr));

   always_comb begin
      rdata_next = '0;
      case (word_idx(s_axi_araddr))
         DYNRC_IDX_CONTROL: rdata_next[15:0] = ctrl_reg;
         DYNRC_IDX_TIMING: rdata_next[15:0] = time_reg;
         DYNRC_IDX_STATUS: rdata_next[2:0] = stat_reg;
         DYNRC_IDX_MASK: rdata_next[2:0] = mask_reg;
         DYNRC_IDX_KNEE2: rdata_next[4:0] = knee2_reg;
         default: rdata_next = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdata_next;
         s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // control outputs
   assign dyn_enable = ctrl_reg[B_ENA];
   assign dyn_path_select = ctrl_reg[B_PATH];
   assign anti_clip_enable = ctrl_reg[B_CLIP];
   assign quick_release_enable = ctrl_reg[B_QR];
   assign noise_gate_enable = ctrl_reg[B_NG];
   assign second_knee_active = ctrl_reg[B_K2];
   assign second_knee_out_level = ctrl_reg[B_K2] ? knee2_reg : 5'h00;

   // floor and ceiling in 0.5 dB units
   always_comb begin
      case (time_reg[F_MING_LO +: 3])
         3'h0: floor_g = GAIN_ZERO;
         3'h1: floor_g = GAIN_ZERO - 8'd24;
         3'h2: floor_g = GAIN_ZERO - 8'd36;
         3'h3: floor_g = GAIN_ZERO - 8'd48;
         default: floor_g = GAIN_ZERO - 8'd72;
      endcase
      case (time_reg[F_MAXG_LO +: 2])
         2'h0: ceil_g = GAIN_ZERO + 8'd24;
         2'h1: ceil_g = GAIN_ZERO + 8'd36;
         2'h2: ceil_g = GAIN_ZERO + 8'd48;
         default: ceil_g = GAIN_ZERO + 8'd72;
      endcase
      crest_thr = 8'd28 + 8'(12 * ctrl_reg[F_PK_LO +: 2]);
      rms_thr = 8'd54 + 8'(3 * ctrl_reg[F_RMS_LO +: 5]); // level as -dB*2
   end

   // rms_level is attenuation below full scale in 0.5 dB units
   always_comb begin
      if (ctrl_reg[B_DMODE]) det_now = rms_level < rms_thr;
      else det_now = crest_level > crest_thr;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         present_reg <= 1'b0;
      end else if (!ctrl_reg[B_ENA] || !ctrl_reg[B_DET]) begin
         present_reg <= 1'b0;
      end else if (sample_strobe) begin
         present_reg <= det_now;
      end
   end
   assign signal_present = present_reg;

   // gain ramp: one half-dB step per sample once the rate count has run down
   always_comb begin
      gain_next = gain_reg;
      rate_next = rate_cnt_reg;
      if (!ctrl_reg[B_ENA]) begin
         gain_next = GAIN_ZERO;
         rate_next = '0;
      end else if (sample_strobe) begin
         if (rate_cnt_reg > 32'(CLK_HZ / FS_HZ)) begin
            rate_next = rate_cnt_reg - 32'(CLK_HZ / FS_HZ);
         end else begin
            if (target_gain < gain_reg) begin
               gain_next = gain_reg - 8'd1;
               rate_next = step_cycles(ATK_BASE_NS, time_reg[F_ATK_LO +: 4] - ATK_FIRST);
            end else if (target_gain > gain_reg) begin
               gain_next = gain_reg + 8'd1;
               rate_next = step_cycles(DCY_BASE_NS, time_reg[F_DCY_LO +: 4]);
            end
         end
      end
      if (gain_next < floor_g) gain_next = floor_g;
      if (gain_next > ceil_g) gain_next = ceil_g;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         gain_reg <= GAIN_ZERO;
         rate_cnt_reg <= '0;
      end else begin
         gain_reg <= gain_next;
         rate_cnt_reg <= rate_next;
      end
   end
   assign applied_gain = gain_reg;

   // status: 0 presence rose, 1 reserved attack code, 2 reserved floor code
   assign stat_set = {time_reg[F_MING_LO +: 3] > MING_LAST,
                      time_reg[F_ATK_LO +: 4] < ATK_FIRST || time_reg[F_ATK_LO +: 4] > ATK_LAST,
                      sample_strobe && det_now && !present_reg && ctrl_reg[B_ENA] && ctrl_reg[B_DET]};

   always_ff @(posedge clk) begin
      if (srst) begin
         stat_reg <= '0;
      end else if (s_axi_arvalid && s_axi_arready && word_idx(s_axi_araddr) == DYNRC_IDX_STATUS) begin
         stat_reg <= stat_set;
      end else begin
         stat_reg <= stat_reg | stat_set;
      end
   end
   assign irq = |(stat_reg & mask_reg);

   gain_bounds_a: assert property (@(posedge clk) disable iff (srst)
      ctrl_reg[B_ENA] |-> ##1 (applied_gain >= $past(floor_g) && applied_gain <= $past(ceil_g)))
      else $error("applied gain out of bounds");
   gain_step_a: assert property (@(posedge clk) disable iff (srst)
      (ctrl_reg[B_ENA] && !sample_strobe && $stable(time_reg)) |=> $stable(gain_reg) || gain_reg == floor_g || gain_reg == ceil_g)
      else $error("gain moved without a sample");
   detect_off_a: assert property (@(posedge clk) disable iff (srst)
      !(ctrl_reg[B_ENA] && ctrl_reg[B_DET]) |=> !signal_present)
      else $error("presence shown while disabled");
   detect_track_a: assert property (@(posedge clk) disable iff (srst)
      (sample_strobe && ctrl_reg[B_ENA] && ctrl_reg[B_DET]) |=> signal_present == $past(det_now))
      else $error("presence not recomputed");
   knee_gate_a: assert property (@(posedge clk) disable iff (srst)
      !ctrl_reg[B_K2] |-> second_knee_out_level == 5'h00)
      else $error("second knee level leaked");
   ctrl_reset_a: assert property (@(posedge clk)
      $past(srst) |-> (!dyn_enable && !dyn_path_select && anti_clip_enable && quick_release_enable && !noise_gate_enable))
      else $error("control reset value wrong");
   timing_reset_a: assert property (@(posedge clk)
      $past(srst) |-> time_reg == DYNRC_TIME_RESET)
      else $error("timing reset value wrong");
   peak_mode_a: assert property (@(posedge clk) disable iff (srst)
      (sample_strobe && ctrl_reg[B_ENA] && ctrl_reg[B_DET] && !ctrl_reg[B_DMODE] && crest_level <= crest_thr)
      |=> !signal_present)
      else $error("peak threshold misapplied");
   bresp_hold_a: assert property (@(posedge clk) disable iff (srst)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   cov_write_c: cover property (@(posedge clk) s_axi_bvalid && s_axi_bready);
   cov_detect_c: cover property (@(posedge clk) $rose(signal_present));
   cov_floor_c: cover property (@(posedge clk) ctrl_reg[B_ENA] && gain_reg == floor_g && floor_g != GAIN_ZERO);
   cov_irq_c: cover property (@(posedge clk) $rose(irq));
endmodule
`default_nettype wire
